// ---- common/tess_pkg.sv ----
package tess_pkg;
  // float constants
  localparam logic [7:0] FP_BIAS = 8'h7F;
  localparam logic [7:0] FP_EXP_MAX = 8'hFF;
  localparam logic [31:0] FP_ONE = 32'h3F800000;
  // level and payload widths
  localparam int CNT_W = 9;
  localparam int PAYLOAD_W = 32;
  localparam logic [CNT_W-1:0] CNT_SAT = 9'h1FF;
  localparam logic [4:0] FP_MANT_BITS = 5'h17;
  localparam logic [7:0] CEIL_SPAN = 8'h07;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OUTER0 = 8'h04;
  localparam logic [7:0] REG_INNER0 = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_LAST = 8'h1C;
  // control field positions
  localparam int CTRL_EVAL = 0;
  localparam int CTRL_CTLSTAGE = 1;
  localparam int CTRL_DOM_LO = 2;
  localparam int CTRL_SPC_LO = 4;
  localparam int CTRL_CW = 6;
  localparam int CTRL_POINT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] ERR_DATA = 32'h00000000;

  typedef enum logic [1:0] {DOM_TRI, DOM_QUAD, DOM_ISO, DOM_RSV} domain_t;
  typedef enum logic [1:0] {SPC_EQUAL, SPC_EVEN, SPC_ODD, SPC_RSV} spacing_t;

  // one patch from the control stage
  typedef struct packed {
    logic [1:0][31:0] interior_level_array;
    logic [3:0][31:0] edge_level_array;
    logic [PAYLOAD_W-1:0] payload;
  } patch_in_t;

  // one processed level
  typedef struct packed {
    logic [CNT_W-1:0] n;
    logic [31:0] clamped;
    logic frac_pair;
  } level_res_t;

  // one patch to the evaluation stage
  typedef struct packed {
    logic bypass;
    domain_t domain;
    logic clockwise_winding;
    logic point_mode;
    logic [1:0] coord_comps;
    logic [5:0][$bits(level_res_t)-1:0] levels;
    patch_in_t raw;
  } patch_out_t;
endpackage : tess_pkg

// ---- logic/tessellation_level_generator.sv ----
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - no evaluation stage configured: forward patch unchanged, no subdivision.
// - triangle, rectangle and line-strip domain selections are supported.
// - positions are normalized; triangle uses three components, others two.
// - defaults of four outer and two inner levels are loaded by software.
// - discard patch on zero, negative or NaN relevant outer level.
// - rectangle checks four outer levels, triangle three, line-strip two.
// - negative inner levels never discard; they are clamped instead.
// - equal, fractional even, fractional odd spacing; equal by default.
// - equal spacing clamps to one..max, rounds up to integer.
// - fractional even clamps to two..max, rounds up to even.
// - fractional odd clamps to one..max-1, rounds up to odd.
// - fractional count one unsplit, else n-2 equal plus two extra.
// - extra segment length shrinks as count minus clamped level grows.
// - extra segments symmetric, identical for identical clamped levels.
// - triangles use configured winding, counter-clockwise by default.
// - point mode emits one point per unique vertex in every domain.
module tessellation_level_generator import tess_pkg::*; #(
  parameter logic [CNT_W-1:0] max_subdivision_level = 9'h040
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // patch input from control stage
  input wire logic in_valid_i,
  input wire patch_in_t in_patch_i,
  output logic in_ready_o,
  // patch output to evaluation stage
  output logic out_valid_o,
  output patch_out_t out_patch_o,
  input wire logic out_ready_i
);

  // ceiling of a positive float: {exact, ceil}, saturating
  function automatic logic [CNT_W:0] fceil(input logic [31:0] f);
    logic [7:0] e;
    logic [23:0] m;
    logic [4:0] sh;
    logic [23:0] ip;
    logic fr;
    logic [CNT_W:0] r;
    e = f[30:23];
    m = {1'b1, f[22:0]};
    sh = 5'h00;
    ip = 24'h000000;
    fr = 1'b0;
    if (f[31] || e == 8'h00) begin
      r = '0;
    end else if (e < FP_BIAS) begin
      r = {1'b0, CNT_W'(1)};
    end else if (e > FP_BIAS + CEIL_SPAN) begin
      r = {1'b1, CNT_SAT};
    end else begin
      sh = FP_MANT_BITS - 5'(e - FP_BIAS);
      ip = m >> sh;
      fr = |(m & ~(24'hFFFFFF << sh));
      r = {~fr, CNT_W'(ip + 24'(fr))};
    end
    return r;
  endfunction : fceil

  // small positive integer to float
  function automatic logic [31:0] i2f(input logic [CNT_W-1:0] k);
    logic [31:0] t;
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < CNT_W; i++) begin
      if (k[i]) begin
        p = 4'(i);
      end
    end
    t = 32'(k) << (FP_MANT_BITS - 5'(p));
    return {1'b0, 8'(FP_BIAS + 8'(p)), t[22:0]};
  endfunction : i2f

  // level that forces a discard: zero, negative or NaN
  function automatic logic bad_level(input logic [31:0] f);
    return f[31] || f[30:0] == 31'h0 ||
      (f[30:23] == FP_EXP_MAX && f[22:0] != 23'h0);
  endfunction : bad_level

  // clamp and round one level under the spacing mode
  function automatic level_res_t lvl_proc(input logic [31:0] f,
                                          input spacing_t s);
    logic [CNT_W:0] c;
    logic [CNT_W-1:0] lo;
    logic [CNT_W-1:0] hi;
    logic below;
    logic above;
    logic [CNT_W-1:0] n;
    level_res_t r;
    c = fceil(f);
    lo = CNT_W'(1);
    hi = max_subdivision_level;
    if (s == SPC_EVEN) begin
      lo = CNT_W'(2);
    end
    if (s == SPC_ODD) begin
      hi = max_subdivision_level - CNT_W'(1);
    end
    below = c[CNT_W-1:0] < lo || (c[CNT_W-1:0] == lo && !c[CNT_W]);
    above = c[CNT_W-1:0] > hi;
    n = below ? lo : (above ? hi : c[CNT_W-1:0]);
    if (s == SPC_EVEN && n[0]) begin
      n = n + CNT_W'(1);
    end
    if (s == SPC_ODD && !n[0]) begin
      n = n + CNT_W'(1);
    end
    r.n = n;
    r.clamped = below ? i2f(lo) : (above ? i2f(hi) : f);
    r.frac_pair = (s == SPC_EVEN || s == SPC_ODD) && n != CNT_W'(1);
    return r;
  endfunction : lvl_proc

  // software state
  logic [7:0] ctrl;
  logic [5:0][31:0] dflt;
  logic [15:0] patch_cnt;
  logic [15:0] discard_cnt;

  // control decode
  wire logic eval_present = ctrl[CTRL_EVAL];
  wire logic ctl_present = ctrl[CTRL_CTLSTAGE];
  wire logic [1:0] dom_raw = ctrl[CTRL_DOM_LO +: 2];
  wire logic [1:0] spc_raw = ctrl[CTRL_SPC_LO +: 2];
  wire domain_t dom = (dom_raw == DOM_RSV) ? DOM_TRI : domain_t'(dom_raw);
  wire spacing_t spc = (spc_raw == SPC_RSV) ? SPC_EQUAL : spacing_t'(spc_raw);

  // apb decode
  wire logic apb_acc = psel_i && penable_i && !pready_o;
  wire logic apb_done = psel_i && penable_i && pready_o;
  wire logic addr_ok = paddr_i[1:0] == 2'h0 && paddr_i <= REG_LAST;
  wire logic [2:0] widx = 3'(paddr_i[7:2]);
  wire logic wr_en = apb_done && pwrite_i && addr_ok;
  wire logic [31:0] status_word = {discard_cnt, patch_cnt};
  wire logic [31:0] rd_word = (paddr_i == REG_CTRL) ? {24'h000000, ctrl} :
    (paddr_i == REG_STATUS) ? status_word : dflt[widx - 3'h1];

  wire logic [5:0][31:0] lvl = ctl_present ?
    {in_patch_i.interior_level_array, in_patch_i.edge_level_array} : dflt;

  wire logic bad0 = bad_level(lvl[0]);
  wire logic bad1 = bad_level(lvl[1]);
  wire logic bad2 = bad_level(lvl[2]) && dom != DOM_ISO;
  wire logic bad3 = bad_level(lvl[3]) && dom == DOM_QUAD;
  wire logic discard = eval_present && (bad0 || bad1 || bad2 || bad3);

  // per-level clamp and rounding
  level_res_t lres [6];
  logic [5:0][$bits(level_res_t)-1:0] lres_pk;
  genvar gi;
  for (gi = 0; gi < 6; gi++) begin : g_lvl
    assign lres[gi] = lvl_proc(lvl[gi], spc);
    assign lres_pk[gi] = lres[gi];
  end

  // output record assembly
  patch_out_t next_out;
  wire logic take = in_valid_i && in_ready_o;
  always_comb begin
    next_out = '0;
    next_out.bypass = !eval_present;
    next_out.raw = in_patch_i;
    if (eval_present) begin
      next_out.domain = dom;
      next_out.clockwise_winding = ctrl[CTRL_CW] && dom != DOM_ISO;
      next_out.point_mode = ctrl[CTRL_POINT];
      next_out.coord_comps = (dom == DOM_TRI) ? 2'h3 : 2'h2;
      next_out.levels = lres_pk;
    end
  end

  // apb registers
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctrl <= CTRL_RESET;
      dflt <= {6{FP_ONE}};
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= ERR_DATA;
    end else begin
      pready_o <= apb_acc;
      pslverr_o <= apb_acc && !addr_ok;
      if (apb_acc) begin
        prdata_o <= (addr_ok && !pwrite_i) ? rd_word : ERR_DATA;
      end
      if (wr_en && paddr_i == REG_CTRL) begin
        ctrl <= pwdata_i[7:0];
      end
      if (wr_en && paddr_i >= REG_OUTER0 && paddr_i < REG_STATUS) begin
        dflt[widx - 3'h1] <= pwdata_i;
      end
    end
  end

  // patch handshake, one patch in flight
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_patch_o <= '0;
      patch_cnt <= 16'h0000;
      discard_cnt <= 16'h0000;
    end else begin
      if (out_valid_o && out_ready_i) begin
        out_valid_o <= 1'b0;
        in_ready_o <= 1'b1;
      end else if (!out_valid_o && !take) begin
        in_ready_o <= 1'b1;
      end
      if (take) begin
        patch_cnt <= patch_cnt + 16'h0001;
        if (discard) begin
          discard_cnt <= discard_cnt + 16'h0001;
        end else begin
          in_ready_o <= 1'b0;
          out_valid_o <= 1'b1;
          out_patch_o <= next_out;
        end
      end
    end
  end

endmodule : tessellation_level_generator

`default_nettype wire

// ---- sim/tess_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module tess_sva import tess_pkg::*; #(
  parameter logic [CNT_W-1:0] max_subdivision_level = 9'h040
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // register bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // patch stream
  input wire logic in_valid_i,
  input wire logic in_ready_o,
  input wire logic out_valid_o,
  input wire patch_out_t out_patch_o,
  input wire logic out_ready_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // first edge result and a processed-patch flag
  wire level_res_t lv0 = out_patch_o.levels[0];
  wire logic proc = out_valid_o && !out_patch_o.bypass;
  // access phase still waiting for its answer
  sequence acc_wait_s;
    psel_i && penable_i && !pready_o;
  endsequence
  apb_wait_a: assert property (acc_wait_s |=> pready_o ##1 !pready_o)
    else $error("apb answer");
  bad_addr_a: assert property (
    pready_o && (paddr_i > REG_LAST || paddr_i[1:0] != 2'h0)
    |-> pslverr_o && prdata_o == ERR_DATA) else $error("bad address");
  hold_out_a: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_patch_o))
    else $error("output dropped");
  take_resp_a: assert property (
    in_valid_i && in_ready_o |=> out_valid_o != in_ready_o)
    else $error("take response");
  bypass_zero_a: assert property (
    out_valid_o && out_patch_o.bypass |-> out_patch_o.levels == '0)
    else $error("bypass levels");
  count_range_a: assert property (
    proc |-> lv0.n >= 9'h001 && lv0.n <= max_subdivision_level)
    else $error("count range");
  coord_fmt_a: assert property (
    proc |-> out_patch_o.coord_comps ==
    (out_patch_o.domain inside {DOM_QUAD, DOM_ISO} ? 2'h2 : 2'h3))
    else $error("coord format");
  unsplit_a: assert property (
    proc && lv0.n == 9'h001 |-> !lv0.frac_pair) else $error("frac pair");
  iso_winding_a: assert property (
    proc && out_patch_o.domain == DOM_ISO
    |-> !out_patch_o.clockwise_winding) else $error("iso winding");
endmodule : tess_sva
bind tessellation_level_generator tess_sva #(
  .max_subdivision_level(max_subdivision_level)
) i_sva (.ref_clk_i, .rstn_i, .psel_i, .penable_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .in_valid_i, .in_ready_o, .out_valid_o,
  .out_patch_o, .out_ready_i);
`default_nettype wire

// ---- sim/eval_stage_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module eval_stage_model (
  // clock, reset and pace
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  // acceptance toward the block
  output logic out_ready_o
);
  logic [1:0] pace;
  // takes at once, or one cycle in four when slow
  always_ff @(posedge ref_clk_i) begin
    pace <= rstn_i ? pace + 2'h1 : 2'h0;
    out_ready_o <= rstn_i && (!slow_i || pace == 2'h3);
  end
endmodule : eval_stage_model
`default_nettype wire

// ---- sim/tessellation_level_generator_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tessellation_level_generator_tb import tess_pkg::*;;
  localparam logic [31:0] F2 = 32'h40000000, F25 = 32'h40200000;
  localparam logic [31:0] F3 = 32'h40400000, F100 = 32'h42C80000;
  localparam logic [31:0] FM1 = 32'hBF800000, NAN = 32'h7FC00000;
  localparam logic [31:0] F63 = 32'h427C0000, F64 = 32'h42800000;
  // block ports and bench state
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, in_valid_i = 1'b0, slow = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, v;
  logic pready_o, pslverr_o, in_ready_o, out_valid_o, out_ready_i;
  patch_in_t in_patch_i = '0;
  patch_out_t out_patch_o;
  level_res_t lv0, lv4;
  logic [87:0] seen, note_q[$];
  integer seed = 63, fail_count = 0, checks_done = 0, cycles = 0;
  tessellation_level_generator i_dut (.ref_clk_i, .rstn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .in_valid_i, .in_patch_i, .in_ready_o, .out_valid_o,
    .out_patch_o, .out_ready_i);
  eval_stage_model i_sink (.ref_clk_i, .rstn_i, .slow_i(slow),
    .out_ready_o(out_ready_i));
  // clock and hang limit
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  task check(input string nm, input logic [87:0] s, e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, e,
    input logic er);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (!w) check("prdata", prdata_o, e);
    check("pslverr", pslverr_o, er);
    @(posedge ref_clk_i);
  endtask : apb
  task run(input logic [7:0] c, input logic [31:0] e, i,
    input logic [3:0] z, input logic [8:0] n0, n4,
    input logic [31:0] f0, input logic fp, keep);
    logic [31:0] p;
    p = $random(seed);
    apb(1'b1, REG_CTRL, {24'h0, c}, 32'h0, 1'b0);
    slow <= p[7];
    in_patch_i.edge_level_array <= {z[3] ? 32'h0 : e, z[2] ? 32'h0 : e,
      z[1] ? 32'h0 : e, z[0] ? 32'h0 : e};
    in_patch_i.interior_level_array <= {i, i};
    in_patch_i.payload <= p;
    in_valid_i <= 1'b1;
    if (keep)
      note_q.push_back({p, n0, n4, c[6] && c[3:2] != 2'h2, c[7], f0, fp,
        !c[0], c[3:2]});
    do @(posedge ref_clk_i); while (in_ready_o !== 1'b1);
    in_valid_i <= 1'b0;
  endtask : run
  // compare each accepted patch with the oldest note
  always @(posedge ref_clk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      lv0 = out_patch_o.levels[0];
      lv4 = out_patch_o.levels[4];
      seen = {out_patch_o.raw.payload, lv0.n, lv4.n,
        out_patch_o.clockwise_winding, out_patch_o.point_mode,
        lv0.clamped, lv0.frac_pair, out_patch_o.bypass,
        out_patch_o.domain};
      check("patch", seen, note_q.pop_front());
    end
  end
  // reset, register checks, then the patch table
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int a = 0; a < 36; a += 4) begin
      v = (a == 0 || a >= 28) ? 32'h0 : FP_ONE;
      apb(1'b0, a[7:0], 32'h0, v, a == 32);
    end
    for (int a = 4; a < 28; a += 4) begin
      v = a < 20 ? F3 : F25;
      apb(1'b1, a[7:0], v, v, 1'b0);
      apb(1'b0, a[7:0], 32'h0, v, 1'b0);
    end
    run(8'h00, F25, F2, 4'hF, 9'h0, 9'h0, 32'h0, 1'b0, 1'b1);
    run(8'h07, F25, FM1, 4'h0, 9'h3, 9'h1, F25, 1'b0, 1'b1);
    run(8'h07, F100, F3, 4'h0, 9'h40, 9'h3, F64, 1'b0, 1'b1);
    run(8'h17, F25, FM1, 4'h0, 9'h4, 9'h2, F25, 1'b1, 1'b1);
    run(8'h27, F25, FM1, 4'h0, 9'h3, 9'h1, F25, 1'b1, 1'b1);
    run(8'h27, F100, F2, 4'h0, 9'h3F, 9'h3, F63, 1'b1, 1'b1);
    run(8'h37, F25, F2, 4'h0, 9'h3, 9'h2, F25, 1'b0, 1'b1);
    run(8'h07, F25, F2, 4'h8, 9'h0, 9'h0, 32'h0, 1'b0, 1'b0);
    run(8'h03, F25, F25, 4'h8, 9'h3, 9'h3, F25, 1'b0, 1'b1);
    run(8'h4B, F25, F25, 4'h4, 9'h3, 9'h3, F25, 1'b0, 1'b1);
    run(8'h0B, F25, F25, 4'h2, 9'h0, 9'h0, 32'h0, 1'b0, 1'b0);
    run(8'h07, NAN, F2, 4'h0, 9'h0, 9'h0, 32'h0, 1'b0, 1'b0);
    run(8'hC7, FP_ONE, FP_ONE, 4'h0, 9'h1, 9'h1, FP_ONE, 1'b0, 1'b1);
    run(8'h05, F25, F25, 4'hF, 9'h3, 9'h3, F3, 1'b0, 1'b1);
    repeat (20) @(posedge ref_clk_i);
    check("notes left", note_q.size(), 88'h0);
    // fourteen patches taken, three of them discarded
    apb(1'b0, REG_STATUS, 32'h0, 32'h0003000E, 1'b0);
    // mid-run reset returns registers and counters to defaults
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    apb(1'b0, REG_CTRL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, REG_OUTER0, 32'h0, FP_ONE, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0, 32'h0, 1'b0);
    complete_run;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
endmodule : tessellation_level_generator_tb
`default_nettype wire
